// ==== config_readout.sv ====
// Serial configuration memory read-out with cascade and programming port
`timescale 1ns/10ps
`default_nettype none

module config_readout
    import readout_pkg::*;
#(
    parameter int unsigned DEPTH = DEPTH_DEFAULT,
    parameter int unsigned AW    = $clog2(DEPTH)
)
(
    // System
    input  wire logic          sys_clk,
    input  wire logic          rst_n,
    // Loader side, sampled on sys_clk
    input  wire logic          loader_clock,
    input  wire logic          chip_select_n,
    input  wire logic          reset_enable,
    input  wire logic          program_mode_select_n,
    // Serial data pin, split into three signals
    input  wire logic          data_in,
    output logic               data_out,
    output logic               data_oe,
    // Cascade to next memory
    output logic               chain_pass_n,
    // Programming-mode inputs
    input  wire logic          guard_input_single,
    input  wire logic          guard_input_one,
    input  wire logic          guard_input_two,
    input  wire logic          program_select_bit,
    input  wire logic          prog_write_req,
    // Open-collector ready indicator
    output logic               ready_out,
    output logic               ready_oe,
    // Polarity configuration write and status
    input  wire logic          pol_write,
    input  wire logic [1:0]    pol_byte_sel,
    input  wire logic [7:0]    pol_byte,
    output logic               standby,
    output logic [AW-1:0]      addr_count
);

    localparam logic [AW-1:0] ADDR_LAST = AW'(DEPTH - 1);
    localparam logic [AW-1:0] LOW_LAST  = AW'(LOW_BLOCK_BITS - 1);
    localparam logic [AW-1:0] QUART     = AW'(DEPTH / 4);
    localparam int unsigned   PUW       = $clog2(POWERUP_CYCLES + 1);
    localparam logic [PUW-1:0] PU_LAST  = PUW'(POWERUP_CYCLES - 1);

    // Depth and address width must fit the single-bit array
    if (DEPTH < DEPTH_MIN || DEPTH > DEPTH_MAX
        || (DEPTH & (DEPTH - 1)) != 0 || AW != $clog2(DEPTH))
    begin : g_bad_depth
        $error("Depth must be a power of two within the family range");
    end

    typedef struct packed
    {
        read_state_t      st;
        logic [AW-1:0]    addr;
        logic [2:0]       bitc;
        logic             clk_d;
        logic             cascade_n;
        logic             drive;
        logic             dout;
        logic [PUW-1:0]   pu_cnt;
        logic [31:0]      pol_word;
    } state_t;

    state_t cur_r;
    state_t cur_nxt;

    logic       rd_bit;
    logic       wr_en;
    logic       clk_rise;
    logic       pol_active_low;
    logic       in_reset;
    logic       out_enable;
    logic       loading;
    logic       selected;
    logic       blocked;

    // Polarity: all-ones word is the default, reset low and enable high
    assign pol_active_low = (cur_r.pol_word == POL_WORD_RESET);
    assign in_reset   = pol_active_low ? !reset_enable : reset_enable;
    assign out_enable = !in_reset;
    assign loading    = program_mode_select_n;
    // Select pin has no say in programming mode
    assign selected   = loading ? !chip_select_n : program_select_bit;
    assign clk_rise   = loader_clock && !cur_r.clk_d;

    // Guards act only in programming; pull-downs mean inactive by default
    always_comb
    begin
        blocked = 1'b0;
        if (!loading)
        begin
            if (guard_input_single && cur_r.addr <= LOW_LAST)
                blocked = 1'b1;
            if (guard_input_one && cur_r.addr < QUART)
                blocked = 1'b1;
            if (guard_input_two && cur_r.addr >= QUART
                && cur_r.addr < AW'(2 * (DEPTH / 4)))
                blocked = 1'b1;
        end
    end

    assign wr_en = !loading && selected && clk_rise && prog_write_req
                   && !blocked && cur_r.st != ST_POWERUP;

    bit_array #(
        .DEPTH (DEPTH),
        .AW    (AW)
    ) u_array (
        .sys_clk (sys_clk),
        .wr_en   (wr_en),
        .wr_addr (cur_r.addr),
        .wr_bit  (data_in),
        .rd_addr (cur_r.addr),
        .rd_bit  (rd_bit)
    );

    always_comb
    begin
        cur_nxt          = cur_r;
        cur_nxt.clk_d    = loader_clock;
        if (pol_write && !loading)
        begin
            cur_nxt.pol_word[pol_byte_sel*8 +: 8] = pol_byte;
        end
        case (cur_r.st)
            ST_POWERUP:
            begin
                cur_nxt.addr  = '0;
                cur_nxt.bitc  = '0;
                cur_nxt.drive = 1'b0;
                cur_nxt.cascade_n = 1'b1;
                if (cur_r.pu_cnt == PU_LAST)
                    cur_nxt.st = ST_IDLE;
                else
                    cur_nxt.pu_cnt = cur_r.pu_cnt + PUW'(1);
            end
            ST_IDLE, ST_READ, ST_DONE:
            begin
                if (loading && in_reset)
                begin
                    // Reset wins over select, whatever its level
                    cur_nxt.addr  = '0;
                    cur_nxt.bitc  = '0;
                    cur_nxt.drive = 1'b0;
                    cur_nxt.st    = ST_IDLE;
                    cur_nxt.cascade_n = 1'b1;
                end
                else if (!loading)
                begin
                    // Programming: counter steps on each clock short of the last address while program_select_bit is set
                    cur_nxt.drive = 1'b0;
                    if (selected && clk_rise && cur_r.addr != ADDR_LAST)
                    begin
                        cur_nxt.addr = cur_r.addr + AW'(1);
                        cur_nxt.bitc = cur_r.bitc + 3'd1;
                    end
                end
                else if (!selected)
                begin
                    // Standby: counters frozen, data floating
                    cur_nxt.drive = 1'b0;
                    if (cur_r.st == ST_DONE)
                        cur_nxt.cascade_n = chip_select_n;
                end
                else
                begin
                    if (cur_r.st == ST_DONE)
                    begin
                        cur_nxt.drive     = 1'b0;
                        cur_nxt.cascade_n = 1'b0;
                    end
                    else
                    begin
                        cur_nxt.st    = ST_READ;
                        cur_nxt.drive = 1'b1;
                        cur_nxt.dout  = rd_bit;
                        if (clk_rise)
                        begin
                            if (cur_r.addr == ADDR_LAST)
                            begin
                                cur_nxt.st        = ST_DONE;
                                cur_nxt.cascade_n = 1'b0;
                                cur_nxt.drive     = 1'b0;
                            end
                            else
                            begin
                                cur_nxt.addr = cur_r.addr + AW'(1);
                                cur_nxt.bitc = cur_r.bitc + 3'd1;
                                cur_nxt.dout = rd_bit;
                            end
                        end
                    end
                end
            end
            default:
            begin
                cur_nxt.st = ST_POWERUP;
            end
        endcase
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            cur_r.st        <= ST_POWERUP;
            cur_r.addr      <= '0;
            cur_r.bitc      <= '0;
            cur_r.clk_d     <= 1'b0;
            cur_r.cascade_n <= 1'b1;
            cur_r.drive     <= 1'b0;
            cur_r.dout      <= 1'b0;
            cur_r.pu_cnt    <= '0;
            cur_r.pol_word  <= POL_WORD_RESET;
        end
        else
        begin
            cur_r <= cur_nxt;
        end
    end

    // Data pin: driven high/low while reading, floating otherwise
    assign data_out     = cur_r.dout;
    assign data_oe      = cur_r.drive;
    assign chain_pass_n = cur_r.cascade_n;
    assign ready_out    = 1'b0;
    assign ready_oe     = (cur_r.st == ST_POWERUP);
    assign standby      = loading && chip_select_n;
    assign addr_count   = cur_r.addr;

    // Loader-driven pins carry no checks here; they are the far side's
    a_reset_clears: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (loading && in_reset && cur_r.st != ST_POWERUP)
        |=> (cur_r.addr == '0 && !data_oe))
        else $error("Reset did not clear the counter");
    a_standby_float: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (loading && chip_select_n) |=> !data_oe)
        else $error("Data driven in standby");
    a_standby_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (loading && chip_select_n && !in_reset && cur_r.st != ST_POWERUP)
        |=> $stable(cur_r.addr))
        else $error("Counter moved in standby");
    a_count_step: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (cur_r.st == ST_READ && loading && !chip_select_n && !in_reset
         && clk_rise && cur_r.addr != ADDR_LAST)
        |=> cur_r.addr == $past(cur_r.addr) + AW'(1))
        else $error("Counter did not advance");
    a_cascade_end: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (cur_r.st == ST_READ && loading && !chip_select_n && !in_reset
         && clk_rise && cur_r.addr == ADDR_LAST)
        |=> (!chain_pass_n && !data_oe && cur_r.addr == ADDR_LAST))
        else $error("Cascade not asserted at end");
    a_drive_on: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (cur_r.st == ST_IDLE && loading && !chip_select_n && !in_reset)
        |=> data_oe)
        else $error("Driver not enabled");
    a_ready_power: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $rose(rst_n) |-> ready_oe [*8])
        else $error("Ready released early");
    a_prog_float: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !loading |=> !data_oe)
        else $error("Data driven in programming");
    a_guard_low: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (!loading && guard_input_single && cur_r.addr <= LOW_LAST)
        |-> !wr_en)
        else $error("Write into protected block");

    // Reading in progress, short of the last address
    sequence s_reading;
        cur_r.st == ST_READ && loading && !chip_select_n && out_enable
        && cur_r.addr != ADDR_LAST;
    endsequence

    // A reset level, then enable with the select still high
    sequence s_reset_then_standby;
        (loading && in_reset && cur_r.st != ST_POWERUP)
        ##1 (loading && out_enable && chip_select_n);
    endsequence

    a_read_drive: assert property (@(posedge sys_clk) disable iff (!rst_n)
        s_reading |=> data_oe)
        else $error("Driver dropped while reading");
    a_select_late: assert property (@(posedge sys_clk) disable iff (!rst_n)
        s_reset_then_standby |=> (cur_r.addr == '0 && !data_oe))
        else $error("Counter or driver on after reset in standby");
    a_reset_cascade: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (loading && in_reset && cur_r.st != ST_POWERUP)
        |=> chain_pass_n)
        else $error("Cascade low after reset");
    a_done_follow: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (cur_r.st == ST_DONE && loading && out_enable)
        |=> chain_pass_n == $past(chip_select_n))
        else $error("Cascade did not follow select after read-out");
    a_done_float: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (cur_r.st == ST_DONE && !chain_pass_n) |-> !data_oe)
        else $error("Data driven after read-out");
    a_done_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (cur_r.st == ST_DONE && !(loading && in_reset))
        |=> cur_r.addr == ADDR_LAST)
        else $error("Counter left its maximum without reset");
    a_prog_step: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (!loading && program_select_bit && clk_rise
         && cur_r.st != ST_POWERUP && cur_r.addr != ADDR_LAST)
        |=> cur_r.addr == $past(cur_r.addr) + AW'(1))
        else $error("Programming clock did not step the counter");
    a_prog_idle: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (!loading && !program_select_bit && cur_r.st != ST_POWERUP)
        |=> $stable(cur_r.addr))
        else $error("Deselected device counted in programming");
    a_guard_portion: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (!loading && guard_input_one && cur_r.addr < QUART)
        |-> !wr_en)
        else $error("Write into guarded portion");
    // The delay equals the sixteen-cycle power-up hold
    a_ready_release: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $rose(rst_n) |-> ##16 !ready_oe)
        else $error("Ready not released after power-up");

endmodule

`default_nettype wire

// ==== readout_pkg.sv ====
// Constants shared by the serial configuration memory read-out block
package readout_pkg;

    // Array depth limits of the family, in bits
    localparam int unsigned DEPTH_MIN     = 65536;
    localparam int unsigned DEPTH_MAX     = 4194304;
    localparam int unsigned DEPTH_DEFAULT = 65536;

    // Polarity configuration: four bytes, all-ones selects the default
    localparam int unsigned POL_BYTES      = 4;
    localparam logic [31:0] POL_WORD_RESET = 32'hffffffff;

    // Power-up hold of the ready indicator, in clock cycles
    localparam int unsigned POWERUP_CYCLES = 16;

    // Protected lowest block size, in bits
    localparam int unsigned LOW_BLOCK_BITS = 4096;

    typedef enum logic [1:0]
    {
        ST_POWERUP,
        ST_IDLE,
        ST_READ,
        ST_DONE
    } read_state_t;

endpackage

// ==== bit_array.sv ====
// Single-bit-wide storage array with one read port and one write port
`timescale 1ns/10ps
`default_nettype none

module bit_array
    import readout_pkg::*;
#(
    parameter int unsigned DEPTH = DEPTH_DEFAULT,
    parameter int unsigned AW    = $clog2(DEPTH)
)
(
    // Clock
    input  wire logic          sys_clk,
    // Write port
    input  wire logic          wr_en,
    input  wire logic [AW-1:0] wr_addr,
    input  wire logic          wr_bit,
    // Read port
    input  wire logic [AW-1:0] rd_addr,
    output logic               rd_bit
);

    logic mem [DEPTH];

    // Asynchronous read keeps the bit in step with the counter
    assign rd_bit = mem[rd_addr];

    always_ff @(posedge sys_clk)
    begin
        if (wr_en)
        begin
            mem[wr_addr] <= wr_bit;
        end
    end

endmodule

`default_nettype wire

// ==== loader_model.sv ====
// Loader-side model: drives the loader clock, select and reset/enable
`timescale 1ns/10ps
`default_nettype none

module loader_model
(
    // System
    input  wire logic sys_clk,
    // Loader controls
    output logic      loader_clock,
    output logic      chip_select_n,
    output logic      reset_enable
);
    initial
    begin
        loader_clock  = 1'b0;
        chip_select_n = 1'b1;
        reset_enable  = 1'b1;
    end

    // Clock rests low between bits; two cycles high, three low
    task automatic pulse();
        @(posedge sys_clk) loader_clock <= 1'b1;
        repeat (2) @(posedge sys_clk);
        loader_clock <= 1'b0;
        repeat (3) @(posedge sys_clk);
    endtask

    // In a chain the select comes from the upstream cascade output
    task automatic set_ctl(input logic cs_n, input logic re);
        @(posedge sys_clk);
        chip_select_n <= cs_n;
        reset_enable  <= re;
    endtask
endmodule

`default_nettype wire

// ==== tb.sv ====
// Self-checking bench for the configuration read-out block
`timescale 1ns/10ps
`default_nettype none

module tb;
    import readout_pkg::*;

    localparam int unsigned DEPTH = 65536;
    localparam logic [7:0]  PAT   = 8'ha5;

    logic        sys_clk, rst_n, loader_clock, chip_select_n, reset_enable;
    logic        program_mode_select_n, data_in, data_out, data_oe;
    logic        chain_pass_n, guard_input_single, guard_input_one;
    logic        guard_input_two, program_select_bit, prog_write_req;
    logic        ready_out, ready_oe, pol_write, standby, wr_bit;
    logic [1:0]  pol_byte_sel;
    logic [7:0]  pol_byte;
    logic [15:0] addr_count;
    int          n_mismatch;
    int          n_checks;

    // Shared data pin: ours only while the block is not driving it
    assign data_in = data_oe ? data_out : wr_bit;

    config_readout #(.DEPTH(DEPTH)) u_config_readout
    (
        .sys_clk(sys_clk), .rst_n(rst_n), .loader_clock(loader_clock),
        .chip_select_n(chip_select_n), .reset_enable(reset_enable),
        .program_mode_select_n(program_mode_select_n), .data_in(data_in),
        .data_out(data_out), .data_oe(data_oe), .chain_pass_n(chain_pass_n),
        .guard_input_single(guard_input_single),
        .guard_input_one(guard_input_one), .guard_input_two(guard_input_two),
        .program_select_bit(program_select_bit),
        .prog_write_req(prog_write_req), .ready_out(ready_out),
        .ready_oe(ready_oe), .pol_write(pol_write),
        .pol_byte_sel(pol_byte_sel), .pol_byte(pol_byte),
        .standby(standby), .addr_count(addr_count)
    );

    loader_model u_loader_model
    (
        .sys_clk(sys_clk), .loader_clock(loader_clock),
        .chip_select_n(chip_select_n), .reset_enable(reset_enable)
    );

    initial
    begin
        sys_clk = 1'b0;
        rst_n = 1'b0;
        {program_mode_select_n, wr_bit} = 2'h3;
        {guard_input_single, guard_input_one, guard_input_two} = 3'h0;
        {program_select_bit, prog_write_req, pol_write} = 3'h0;
        pol_byte_sel = 2'h0;
        pol_byte = 8'h00;
        n_mismatch = 0;
        n_checks = 0;
    end

    always #20 sys_clk = ~sys_clk;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic settle();
        repeat (2) @(posedge sys_clk);
        #1;
    endtask

    task automatic t_powerup();
        @(posedge sys_clk) rst_n <= 1'b0;
        repeat (10) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(posedge sys_clk);
        #1;
        chk(ready_oe, 1'b1);
        chk(addr_count, 0);
        chk(data_oe, 1'b0);
        chk(chain_pass_n, 1'b1);
        chk(ready_out, 1'b0);
        repeat (20) @(posedge sys_clk);
        #1;
        chk(ready_oe, 1'b0);
    endtask

    // Write bit b at the current programming position
    task automatic prog_bit(input logic b, input logic sel);
        @(posedge sys_clk);
        program_mode_select_n <= 1'b0;
        program_select_bit <= sel;
        prog_write_req <= 1'b1;
        wr_bit <= b;
        u_loader_model.pulse();
        @(posedge sys_clk);
        {program_mode_select_n, prog_write_req, wr_bit} <= 3'h5;
    endtask

    task automatic t_program();
        u_loader_model.set_ctl(1'b1, 1'b1);
        for (int i = 0; i < 8; i++)
            prog_bit(PAT[i], 1'b1);
        settle();
        chk(addr_count, 8);
        prog_bit(1'b0, 1'b0);
        settle();
        chk(addr_count, 8);
    endtask

    task automatic t_read();
        u_loader_model.set_ctl(1'b1, 1'b0);
        u_loader_model.set_ctl(1'b0, 1'b1);
        @(posedge sys_clk) guard_input_two <= 1'b1;
        settle();
        chk(data_oe, 1'b1);
        for (int i = 0; i < 8; i++)
        begin
            chk(data_out, PAT[i]);
            u_loader_model.pulse();
            #1;
            chk(addr_count, i + 1);
        end
        @(posedge sys_clk) guard_input_two <= 1'b0;
    endtask

    task automatic t_standby();
        u_loader_model.set_ctl(1'b1, 1'b1);
        settle();
        chk(standby, 1'b1);
        chk(data_oe, 1'b0);
        u_loader_model.pulse();
        settle();
        chk(addr_count, 8);
        u_loader_model.set_ctl(1'b1, 1'b0);
        u_loader_model.set_ctl(1'b1, 1'b1);
        settle();
        chk({data_oe, addr_count}, 0);
        u_loader_model.set_ctl(1'b0, 1'b1);
        u_loader_model.pulse();
        settle();
        chk({data_oe, addr_count}, 17'h10001);
        u_loader_model.set_ctl(1'b0, 1'b0);
        settle();
        chk({data_oe, addr_count}, 0);
    endtask

    task automatic t_polarity();
        // Polarity bytes are only taken in programming mode
        @(posedge sys_clk) program_mode_select_n <= 1'b0;
        for (int k = 0; k < POL_BYTES; k++)
        begin
            @(posedge sys_clk);
            pol_write <= 1'b1;
            pol_byte_sel <= 2'(k);
            @(posedge sys_clk) pol_write <= 1'b0;
        end
        @(posedge sys_clk) program_mode_select_n <= 1'b1;
        u_loader_model.set_ctl(1'b0, 1'b1);
        settle();
        chk({data_oe, addr_count}, 0);
        u_loader_model.set_ctl(1'b0, 1'b0);
        u_loader_model.pulse();
        settle();
        chk({data_oe, addr_count}, 17'h10001);
    endtask

    // Writes under the low-block or first-quarter guard leave bit 0 alone; unguarded and second-quarter-guarded ones land
    task automatic t_guard();
        for (int g = 0; g < 4; g++)
        begin
            u_loader_model.set_ctl(1'b1, 1'b0);
            u_loader_model.set_ctl(1'b1, 1'b1);
            @(posedge sys_clk);
            guard_input_single <= (g == 0);
            guard_input_one <= (g == 1);
            guard_input_two <= (g == 3);
            prog_bit((g == 3) ? PAT[0] : !PAT[0], 1'b1);
            @(posedge sys_clk);
            {guard_input_single, guard_input_one, guard_input_two} <= 3'h0;
            u_loader_model.set_ctl(1'b1, 1'b0);
            u_loader_model.set_ctl(1'b0, 1'b1);
            settle();
            chk(data_out, (g == 2) ? !PAT[0] : PAT[0]);
        end
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // A full pass to the last address would far exceed the run budget
    initial
    begin
        t_powerup();
        t_program();
        t_read();
        t_standby();
        t_polarity();
        t_powerup();
        t_guard();
        finish_test();
    end

    initial
    begin
        #(40 * 5000);
        n_mismatch++;
        finish_test();
    end
endmodule

`default_nettype wire
